// file: logic/ucfg_uart_cfg.sv
// UART configuration block: divisor, flow characters, interrupt mask,
// sticky interrupt status and receive halt.
// Assumes a 40 MHz core clock and a register port that never waits.
//
// What this block does
// - Divisor low byte is read/write and resets to 08h.
// - Divisor high byte is read/write and resets to 00h.
// - Baud reference is the 96 MHz master divided by 6.5.
// - Bit rate is reference divided by divisor times sixteen.
// - Any divisor, including those slower than 1200 bps, is accepted.
// - Resume character match interrupts when its enable is set.
// - Resume character is the byte sent as a resume symbol.
// - Pause character match halts receive DMA and may interrupt.
// - Pause character is the byte sent as a pause symbol.
// - Resume character register is 8-bit read/write, reset zero.
// - Pause character register is 8-bit read/write, reset zero.
// - Mask bit 0 enables modem-line-change interrupt, resets 0.
// - Mask bit 1 enables line-status interrupt, resets 0.
// - Mask bit 2 enables transmitter-empty and receiver-full, resets 0.
// - Mask bits 7 to 3 are read-only zero.
//
// Local design decision: strobed register access.
module ucfg_uart_cfg
   import ucfg_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // Register port
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Received character stream
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   // Flow symbol requests and transmit byte
   input  wire logic        send_resume,
   input  wire logic        send_pause,
   output logic             tx_flow_valid,
   output logic      [7:0]  tx_flow_byte,
   // UART event inputs
   input  wire logic        modem_change,
   input  wire logic        line_status_event,
   input  wire logic        transmitter_empty,
   input  wire logic        receiver_full,
   // Baud ticks
   output logic             os_tick,
   output logic             bit_tick,
   // Receive DMA halt and interrupt
   output logic             rx_dma_halt,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [7:0] baud_divisor_low;
   logic [7:0] divisor_high_byte;
   logic [7:0] resume_char;
   logic [7:0] pause_char;
   logic [7:0] uart_irq_mask;
   logic [7:0] irq_status;
   logic [7:0] flow_irq_enable;
   logic       div_restart;
   logic       resume_hit;
   logic       pause_hit;

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   wire sel_div_low   = reg_addr == ADDR_DIV_LOW;
   wire sel_div_high  = reg_addr == ADDR_DIV_HIGH;
   wire sel_resume    = reg_addr == ADDR_RESUME;
   wire sel_pause     = reg_addr == ADDR_PAUSE;
   wire sel_mask      = reg_addr == ADDR_IRQ_MASK;
   wire sel_stat      = reg_addr == ADDR_IRQ_STAT;
   wire sel_flow_en   = reg_addr == ADDR_FLOW_EN;
   wire sel_flow_ctrl = reg_addr == ADDR_FLOW_CTRL;

   wire wr_div_low    = reg_wr && sel_div_low;
   wire wr_div_high   = reg_wr && sel_div_high;
   wire wr_resume     = reg_wr && sel_resume;
   wire wr_pause      = reg_wr && sel_pause;
   wire wr_mask       = reg_wr && sel_mask;
   wire wr_stat       = reg_wr && sel_stat;
   wire wr_flow_en    = reg_wr && sel_flow_en;
   wire wr_flow_ctrl  = reg_wr && sel_flow_ctrl;

   ////////////////////////////////////////////////////////////////////////
   // Divisor registers
   // No range limit on divisor
   wire [15:0] divisor = {divisor_high_byte, baud_divisor_low};

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         baud_divisor_low <= RST_DIV_LOW;
      else if (wr_div_low)
         baud_divisor_low <= reg_wdata;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         divisor_high_byte <= RST_DIV_HIGH;
      else if (wr_div_high)
         divisor_high_byte <= reg_wdata;
   end

   // Restart counters so a new rate takes effect cleanly
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         div_restart <= 1'b0;
      else
         div_restart <= wr_div_low || wr_div_high;
   end

   ////////////////////////////////////////////////////////////////////////
   // Flow characters
   // Resume character storage
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         resume_char <= RST_RESUME;
      else if (wr_resume)
         resume_char <= reg_wdata;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         pause_char <= RST_PAUSE;
      else if (wr_pause)
         pause_char <= reg_wdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt mask and flow enables
   // Modem, line-status and transmitter/receiver enable bits
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         uart_irq_mask <= RST_MASK;
      else if (wr_mask)
         uart_irq_mask <= reg_wdata & MASK_RW_BITS;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         flow_irq_enable <= RST_FLOW_EN;
      else if (wr_flow_en)
         flow_irq_enable <= reg_wdata & FLOW_EN_BITS;
   end

   wire [7:0] irq_enable = uart_irq_mask | flow_irq_enable;

   ////////////////////////////////////////////////////////////////////////
   // Sticky status; a set in the clearing cycle survives
   logic [7:0] stat_set;
   always_comb begin
      stat_set              = 8'h00;
      stat_set[BIT_MODEM]   = modem_change;
      stat_set[BIT_LINE]    = line_status_event;
      stat_set[BIT_TXRX]    = transmitter_empty || receiver_full;
      stat_set[BIT_RESUME]  = resume_hit;
      stat_set[BIT_PAUSE]   = pause_hit;
   end

   wire [7:0] stat_clr        = wr_stat ? reg_wdata : 8'h00;
   wire [7:0] next_irq_status = ((irq_status & ~stat_clr) | stat_set) & STAT_BITS;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         irq_status <= RST_STAT;
      else
         irq_status <= next_irq_status;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         irq <= 1'b0;
      else
         irq <= |(next_irq_status & irq_enable);
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive halt; a new pause beats a release in the same cycle
   wire halt_release = resume_hit || (wr_flow_ctrl && reg_wdata[BIT_HALT]);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         rx_dma_halt <= 1'b0;
      else if (pause_hit)
         rx_dma_halt <= 1'b1;
      else if (halt_release)
         rx_dma_halt <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Flow symbol transmit; pause wins since stopping the peer is urgent
   wire       flow_req       = send_pause || send_resume;
   wire [7:0] next_flow_byte = send_pause ? pause_char : resume_char;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_flow_valid <= 1'b0;
         tx_flow_byte  <= 8'h00;
      end else begin
         tx_flow_valid <= flow_req;
         if (flow_req)
            tx_flow_byte <= next_flow_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped offsets read zero
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      case (1'b1)
         sel_div_low:   rd_mux = baud_divisor_low;
         sel_div_high:  rd_mux = divisor_high_byte;
         sel_resume:    rd_mux = resume_char;
         sel_pause:     rd_mux = pause_char;
         sel_mask:      rd_mux = uart_irq_mask;
         sel_stat:      rd_mux = irq_status;
         sel_flow_en:   rd_mux = flow_irq_enable;
         sel_flow_ctrl: rd_mux = {7'h00, rx_dma_halt};
         default:       rd_mux = 8'h00;
      endcase
   end

   // Data holds only in the cycle after the read strobe
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // Submodules
   // Oversampling tick source
   ucfg_baud_gen #(
      .OSR      (OVERSAMPLE)
   ) u_baud (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .divisor  (divisor),
      .restart  (div_restart),
      .ref_tick (),
      .os_tick  (os_tick),
      .bit_tick (bit_tick)
   );

   ucfg_flow_match u_match (
      .core_clk    (core_clk),
      .rst_b       (rst_b),
      .rx_valid    (rx_valid),
      .rx_data     (rx_data),
      .resume_char (resume_char),
      .pause_char  (pause_char),
      .resume_hit  (resume_hit),
      .pause_hit   (pause_hit)
   );

endmodule // ucfg_uart_cfg

// file: logic/ucfg_pkg.sv
// Shared constants for the UART configuration block: register map,
// reset values, field positions and baud timing figures.
// Assumes a single 40 MHz core clock and an 8-bit register port.
package ucfg_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [15:0] ADDR_DIV_LOW   = 16'hFFA7;
   localparam logic [15:0] ADDR_DIV_HIGH  = 16'hFFA8;
   localparam logic [15:0] ADDR_RESUME    = 16'hFFA9;
   localparam logic [15:0] ADDR_PAUSE     = 16'hFFAA;
   localparam logic [15:0] ADDR_IRQ_MASK  = 16'hFFAB;
   localparam logic [15:0] ADDR_IRQ_STAT  = 16'hFFAC;
   localparam logic [15:0] ADDR_FLOW_EN   = 16'hFFAD;
   localparam logic [15:0] ADDR_FLOW_CTRL = 16'hFFAE;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_DIV_LOW  = 8'h08;
   localparam logic [7:0] RST_DIV_HIGH = 8'h00;
   localparam logic [7:0] RST_RESUME   = 8'h00;
   localparam logic [7:0] RST_PAUSE    = 8'h00;
   localparam logic [7:0] RST_MASK     = 8'h00;
   localparam logic [7:0] RST_STAT     = 8'h00;
   localparam logic [7:0] RST_FLOW_EN  = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt field positions, shared by status and enable vectors, and the flow control halt bit
   localparam int BIT_MODEM   = 0;
   localparam int BIT_LINE    = 1;
   localparam int BIT_TXRX    = 2;
   localparam int BIT_RESUME  = 3;
   localparam int BIT_PAUSE   = 4;
   localparam int BIT_HALT    = 0;
   localparam logic [7:0] MASK_RW_BITS = 8'h07;
   localparam logic [7:0] FLOW_EN_BITS = 8'h18;
   localparam logic [7:0] STAT_BITS    = 8'h1F;

   ////////////////////////////////////////////////////////////////////////
   // Baud timing
   localparam int MASTER_CLK_HZ = 96_000_000;
   localparam int PRE_DIV_X2    = 13;
   localparam int CORE_CLK_HZ   = 40_000_000;
   localparam int OVERSAMPLE    = 16;
   // Reference tick rate = core * STEP / MOD = master / 6.5
   localparam logic [31:0] REF_STEP = 32'(MASTER_CLK_HZ * 2);
   localparam logic [31:0] REF_MOD  = 32'(PRE_DIV_X2 * CORE_CLK_HZ);

endpackage

// file: logic/ucfg_baud_gen.sv
// Baud generator: fractional reference tick, divisor counter and
// oversampling counter. Assumes restart is a one-cycle pulse.
module ucfg_baud_gen
   import ucfg_pkg::*;
#(
   parameter int OSR = OVERSAMPLE
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // Control
   input  wire logic [15:0] divisor,
   input  wire logic        restart,
   // Ticks
   output logic             ref_tick,
   output logic             os_tick,
   output logic             bit_tick
);
   localparam int OW = $clog2(OSR);

   logic [31:0]   acc;
   logic [15:0]   div_cnt;
   logic [OW-1:0] os_cnt;

   ////////////////////////////////////////////////////////////////////////
   wire  [31:0] acc_sum  = acc + REF_STEP;
   wire         acc_wrap = acc_sum >= REF_MOD;
   wire  [31:0] next_acc = acc_wrap ? acc_sum - REF_MOD : acc_sum;
   // Divisor zero gives no ticks rather than a runaway rate
   wire         div_end  = (divisor != 16'h0000) &&
                           ({1'b0, div_cnt} + 17'h00001 >= {1'b0, divisor});
   wire         os_end   = os_cnt == OW'(OSR - 1);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         acc      <= 32'h0;
         ref_tick <= 1'b0;
      end else begin
         acc      <= next_acc;
         ref_tick <= acc_wrap;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt <= 16'h0000;
         os_tick <= 1'b0;
      end else if (restart) begin
         div_cnt <= 16'h0000;
         os_tick <= 1'b0;
      end else begin
         os_tick <= ref_tick && div_end;
         if (ref_tick)
            div_cnt <= div_end ? 16'h0000 : div_cnt + 16'h0001;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         os_cnt   <= '0;
         bit_tick <= 1'b0;
      end else if (restart) begin
         os_cnt   <= '0;
         bit_tick <= 1'b0;
      end else begin
         bit_tick <= os_tick && os_end;
         if (os_tick)
            os_cnt <= os_end ? '0 : os_cnt + OW'(1);
      end
   end

endmodule // ucfg_baud_gen

// file: logic/ucfg_flow_match.sv
// Compares each received character with the resume and pause
// characters. Assumes rx_valid marks one character per cycle.
module ucfg_flow_match (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   // Received stream
   input  wire logic       rx_valid,
   input  wire logic [7:0] rx_data,
   // Programmed characters
   input  wire logic [7:0] resume_char,
   input  wire logic [7:0] pause_char,
   // Match pulses
   output logic            resume_hit,
   output logic            pause_hit
);
   wire is_resume = rx_valid && (rx_data == resume_char);
   wire is_pause  = rx_valid && (rx_data == pause_char);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         resume_hit <= 1'b0;
         pause_hit  <= 1'b0;
      end else begin
         resume_hit <= is_resume;
         pause_hit  <= is_pause;
      end
   end

endmodule // ucfg_flow_match

// file: bench/ucfg_uart_cfg_props.sv
// Checker for the UART configuration block, bound to its top module.
// Assumes one core clock and shadows of the characters and mask written.
module ucfg_uart_cfg_props
   import ucfg_pkg::*;
(
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rst_b,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   // Received stream
   input wire logic        rx_valid,
   input wire logic [7:0]  rx_data,
   // Flow symbols
   input wire logic        send_resume,
   input wire logic        send_pause,
   input wire logic        tx_flow_valid,
   input wire logic [7:0]  tx_flow_byte,
   // Events
   input wire logic        modem_change,
   input wire logic        line_status_event,
   input wire logic        transmitter_empty,
   input wire logic        receiver_full,
   // Ticks, halt and interrupt
   input wire logic        os_tick,
   input wire logic        bit_tick,
   input wire logic        rx_dma_halt,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] rch;
   logic [7:0] pch;
   logic [2:0] msk;

   ////////////////////////////////////////////////////////////////////////
   // Shadows follow writes with the same one-cycle take-up as the block
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rch <= 8'h00;
         pch <= 8'h00;
         msk <= 3'h0;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_RESUME) rch <= reg_wdata;
         if (reg_addr == ADDR_PAUSE) pch <= reg_wdata;
         if (reg_addr == ADDR_IRQ_MASK) msk <= reg_wdata[2:0];
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   ////////////////////////////////////////////////////////////////////////
   rdata_idle_a: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read slot");
   mask_rsv_a: assert property (
      $past(reg_rd) && $past(reg_addr) == ADDR_IRQ_MASK |-> reg_rdata[7:3] == 5'h00)
      else $error("mask reserved bits not zero");
   mask_read_a: assert property (
      $past(reg_rd) && $past(reg_addr) == ADDR_IRQ_MASK |-> reg_rdata[2:0] == msk)
      else $error("mask readback wrong");
   resume_byte_a: assert property (
      send_resume && !send_pause |=> tx_flow_valid && tx_flow_byte == $past(rch))
      else $error("resume byte wrong");
   pause_byte_a: assert property (
      send_pause |=> tx_flow_valid && tx_flow_byte == $past(pch)) else $error("pause byte wrong");
   flow_idle_a: assert property (
      !send_resume && !send_pause |=> !tx_flow_valid) else $error("flow valid without request");
   pause_halt_a: assert property (
      rx_valid && rx_data == pch |-> ##2 rx_dma_halt) else $error("pause match did not halt");
   modem_irq_a: assert property (
      modem_change && msk[0] |=> irq) else $error("modem interrupt missing");
   line_irq_a: assert property (
      line_status_event && msk[1] |=> irq) else $error("line status interrupt missing");
   txrx_irq_a: assert property (
      (transmitter_empty || receiver_full) && msk[2] |=> irq) else $error("txe rxf interrupt missing");
   os_gap_a: assert property (
      os_tick |=> !os_tick) else $error("oversample ticks too close");

   halt_c: cover property ($rose(rx_dma_halt));
   irq_c: cover property ($rose(irq));
   bit_c: cover property (bit_tick);
endmodule // ucfg_uart_cfg_props

bind ucfg_uart_cfg ucfg_uart_cfg_props i_props (
   .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
   .rx_data(rx_data), .send_resume(send_resume), .send_pause(send_pause),
   .tx_flow_valid(tx_flow_valid), .tx_flow_byte(tx_flow_byte), .modem_change(modem_change),
   .line_status_event(line_status_event), .transmitter_empty(transmitter_empty),
   .receiver_full(receiver_full), .os_tick(os_tick), .bit_tick(bit_tick),
   .rx_dma_halt(rx_dma_halt), .irq(irq)
);

// file: bench/ucfg_peer.sv
// Serial peer model: hands received characters to the block one at a time.
// Assumes the bench calls send from a single process.
module ucfg_peer (
   // Clock
   input  wire logic       core_clk,
   // Received stream
   output logic            rx_valid,
   output logic      [7:0] rx_data
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'hA5;
   end

   // Data inverts off the strobe so a stale match cannot pass
   task send(input logic [7:0] c);
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_data  <= c;
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_data  <= ~c;
   endtask
endmodule // ucfg_peer

// file: bench/tb_top.sv
// Testbench for the UART configuration block with a serial peer model.
// Assumes a 40 MHz core clock and the register port timing of the block.
module tb_top
   import ucfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        core_clk, rst_b, reg_wr, reg_rd, rx_valid, send_resume, send_pause;
   logic        tx_flow_valid, os_tick, bit_tick, rx_dma_halt, irq;
   logic [15:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, rx_data, tx_flow_byte;
   logic [3:0]  ev;
   int          fails, cmp_count;

   ucfg_uart_cfg i_dut (
      .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
      .rx_data(rx_data), .send_resume(send_resume), .send_pause(send_pause),
      .tx_flow_valid(tx_flow_valid), .tx_flow_byte(tx_flow_byte), .modem_change(ev[0]),
      .line_status_event(ev[1]), .transmitter_empty(ev[2]), .receiver_full(ev[3]),
      .os_tick(os_tick), .bit_tick(bit_tick), .rx_dma_halt(rx_dma_halt), .irq(irq)
   );
   ucfg_peer i_peer (.core_clk(core_clk), .rx_valid(rx_valid), .rx_data(rx_data));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask

   task automatic flow(input logic r, input logic p, input logic [7:0] e);
      @(posedge core_clk);
      send_resume <= r;
      send_pause  <= p;
      @(posedge core_clk);
      send_resume <= 1'b0;
      send_pause  <= 1'b0;
      #1 chk({7'h00, tx_flow_valid}, 8'h01);
      chk(tx_flow_byte, e);
      @(posedge core_clk) #1 chk({7'h00, tx_flow_valid}, 8'h00);
      chk(tx_flow_byte, e);
   endtask

   task automatic rx_expect(input logic [7:0] c, input logic h, input logic i);
      i_peer.send(c);
      @(posedge core_clk) #1 chk({7'h00, rx_dma_halt}, {7'h00, h});
      chk({7'h00, irq}, {7'h00, i});
   endtask

   task automatic ev_pulse(input int i);
      @(posedge core_clk);
      ev <= 4'h1 << i;
      @(posedge core_clk);
      ev <= 4'h0;
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd(ADDR_DIV_LOW, 8'h08);
      rd(ADDR_DIV_HIGH, 8'h00);
      rd(ADDR_RESUME, 8'h00);
      rd(ADDR_PAUSE, 8'h00);
      rd(ADDR_IRQ_MASK, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_regs();
      wr(ADDR_DIV_LOW, 8'h5A);
      wr(ADDR_DIV_HIGH, 8'hA5);
      wr(ADDR_RESUME, 8'h3C);
      wr(ADDR_PAUSE, 8'hC3);
      wr(ADDR_IRQ_MASK, 8'hFF);
      wr(16'hFFB0, 8'hFF);
      wr(ADDR_FLOW_EN, 8'hFF);
      rd(ADDR_FLOW_EN, 8'h18);
      rd(ADDR_DIV_LOW, 8'h5A);
      rd(ADDR_DIV_HIGH, 8'hA5);
      rd(ADDR_RESUME, 8'h3C);
      rd(ADDR_PAUSE, 8'hC3);
      rd(ADDR_IRQ_MASK, 8'h07);
      rd(16'hFFB0, 8'h00);
      wr(ADDR_IRQ_MASK, 8'h00);
      $display("test registers done");
   endtask

   task automatic t_flow();
      wr(ADDR_RESUME, 8'h11);
      wr(ADDR_PAUSE, 8'h13);
      flow(1'b1, 1'b0, 8'h11);
      flow(1'b0, 1'b1, 8'h13);
      flow(1'b1, 1'b1, 8'h13);
      wr(ADDR_FLOW_EN, 8'h18);
      rx_expect(8'h13, 1'b1, 1'b1);
      rx_expect(8'h55, 1'b1, 1'b1);
      rd(ADDR_IRQ_STAT, 8'h10);
      wr(ADDR_IRQ_STAT, 8'h10);
      @(posedge core_clk) #1 chk({7'h00, irq}, 8'h00);
      rx_expect(8'h11, 1'b0, 1'b1);
      rd(ADDR_IRQ_STAT, 8'h08);
      wr(ADDR_IRQ_STAT, 8'h08);
      wr(ADDR_FLOW_EN, 8'h00);
      rx_expect(8'h13, 1'b1, 1'b0);
      rd(ADDR_FLOW_CTRL, 8'h01);
      wr(ADDR_FLOW_CTRL, 8'h01);
      @(posedge core_clk) #1 chk({7'h00, rx_dma_halt}, 8'h00);
      rd(ADDR_FLOW_CTRL, 8'h00);
      rx_expect(8'h11, 1'b0, 1'b0);
      wr(ADDR_IRQ_STAT, 8'h18);
      $display("test flow done");
   endtask

   task automatic t_events();
      ev_pulse(0);
      chk({7'h00, irq}, 8'h00);
      rd(ADDR_IRQ_STAT, 8'h01);
      wr(ADDR_IRQ_STAT, 8'h01);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_IRQ_MASK, 8'h01 << ((i < 3) ? i : 2));
         ev_pulse(i);
         chk({7'h00, irq}, 8'h01);
         wr(ADDR_IRQ_STAT, 8'h07);
         wr(ADDR_IRQ_MASK, 8'h00);
      end
      $display("test events done");
   endtask

   // Two bit ticks after restart bound the period against the ratio
   task automatic t_baud(input logic [15:0] d);
      int     n;
      int     o;
      longint e;
      logic   ok;
      wr(ADDR_DIV_LOW, d[7:0]);
      wr(ADDR_DIV_HIGH, d[15:8]);
      @(posedge core_clk) #1;
      while (bit_tick !== 1'b1) @(posedge core_clk) #1;
      n = 0;
      o = 0;
      do begin
         @(posedge core_clk) #1;
         n++;
         o += int'(os_tick === 1'b1);
      end while (bit_tick !== 1'b1);
      e  = longint'(d) * OVERSAMPLE * REF_MOD;
      ok = (longint'(n) * REF_STEP + REF_STEP >= e) && (longint'(n) * REF_STEP <= e + REF_STEP);
      chk({7'h00, ok}, 8'h01);
      chk(8'(o), 8'h10);
      $display("test baud %h done", d);
   endtask

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      fails = 0;
      cmp_count = 0;
      rst_b = 1'b0;
      {reg_wr, reg_rd, send_resume, send_pause} = 4'h0;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      ev = 4'h0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      t_reset();
      t_regs();
      t_flow();
      t_events();
      t_baud(16'h0001);
      t_baud(16'h0320);
      conclude();
   end

   initial begin
      #2_400_000;
      fails++;
      conclude();
   end
endmodule // tb_top
